// [logic/malc_pkg.sv]
// Constants for the max-address lock and set command block
package malc_pkg;
   // Task file register addresses on the plain register port
   localparam logic [3:0] MALC_A_DATA    = 4'h0;
   localparam logic [3:0] MALC_A_FEAT    = 4'h1; // Write feature, read error
   localparam logic [3:0] MALC_A_SCNT    = 4'h2;
   localparam logic [3:0] MALC_A_SNUM    = 4'h3;
   localparam logic [3:0] MALC_A_CYLLO   = 4'h4;
   localparam logic [3:0] MALC_A_CYLHI   = 4'h5;
   localparam logic [3:0] MALC_A_DEVHD   = 4'h6;
   localparam logic [3:0] MALC_A_CMD     = 4'h7; // Write command, read status
   localparam logic [3:0] MALC_A_DEVCTL  = 4'h8;
   localparam logic [3:0] MALC_A_LOCKST  = 4'h9;
   // Command opcodes and subcommand features
   localparam logic [7:0] MALC_OP_RNM    = 8'hF8;
   localparam logic [7:0] MALC_OP_RNMX   = 8'h27;
   localparam logic [7:0] MALC_OP_SETMAX = 8'hF9;
   localparam logic [7:0] MALC_OP_SETMX  = 8'h37;
   localparam logic [7:0] MALC_FT_PWD    = 8'h01;
   localparam logic [7:0] MALC_FT_LOCK   = 8'h02;
   localparam logic [7:0] MALC_FT_UNLOCK = 8'h03;
   localparam logic [7:0] MALC_FT_FREEZE = 8'h04;
   // Status, error and control bit positions
   localparam int MALC_ST_RDY = 6;
   localparam int MALC_ST_DRQ = 3;
   localparam int MALC_ST_ERR = 0;
   localparam int MALC_ER_ABT = 2;
   localparam int MALC_DC_HOB = 7;
   localparam int MALC_SC_NV  = 0;
   // Counts and limits
   localparam logic [2:0]  MALC_TRIES_RST = 3'h5;
   localparam logic [7:0]  MALC_PWD_FIRST = 8'h01;
   localparam logic [7:0]  MALC_PWD_LAST  = 8'h10;
   localparam logic [7:0]  MALC_SECT_LAST = 8'hFF;
   localparam logic [47:0] MALC_LIM28     = 48'h0000_0FFF_FFFF;
   // Reset values
   localparam logic [7:0]  MALC_STAT_RST  = 8'h40;
   // Phase of the command engine
   typedef enum logic {
      MALC_IDLE = 1'b0,
      MALC_DATA = 1'b1
   } malc_phase_e;
   // Protection state
   typedef enum logic [1:0] {
      MALC_UNLOCKED = 2'b00,
      MALC_LOCKED   = 2'b01,
      MALC_FROZEN   = 2'b11
   } malc_lock_e;
endpackage : malc_pkg

// [logic/malc_top.sv]
// Max-address lock, unlock, freeze and extended set command logic
//
// Contract
// - Opcode F9h with feature 03h selects the password unlock subcommand.
// - F9h right after read-native-max acts as plain set-max-address.
// - Unlock takes one data sector; its password is compared with stored one.
// - Password mismatch aborts the command and decrements the attempt counter.
// - Attempt counter starts at five, loses one per failed compare.
// - Counter at zero rejects every unlock until hardware reset.
// - Matching password enters unlocked state; lock, unlock and freeze then accepted, 01h still aborts.
// - F9h with feature 04h freezes the device.
// - Frozen device rejects every later max-address subcommand.
// - Opcode 37h sets 48-bit max from current and previous address bytes.
// - Media accesses above the set maximum are aborted.
// - Max above 268,435,455 updates 48-bit identify words only.
// - Max up to 268,435,455 updates both 48-bit and 28-bit words.
// - 37h aborts: unsupported, too big, 28-bit area set, not preceded, locked.
// - Second non-volatile 37h aborts until reset.
// - Sector count bit 0 selects non-volatile; invalid in offset mode.
// - Completion returns set address; HOB selects the upper bytes.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module malc_top (
   input  wire logic          clk_in,
   input  wire logic          arst_n_in,
   input  wire logic [3:0]    addr_in,
   input  wire logic [15:0]   wr_data_in,
   input  wire logic          wr_stb_in,
   input  wire logic          rd_stb_in,
   input  wire logic          supported_in,
   input  wire logic          offset_mode_in,
   input  wire logic [47:0]   native_max_in,
   input  wire logic [255:0]  stored_pwd_in,
   input  wire logic          access_req_in,
   input  wire logic [47:0]   access_lba_in,
   output logic [15:0]        rd_data_out,
   output logic               drq_out,
   output logic [47:0]        max_lba_out,
   output logic               max_nv_out,
   output logic [27:0]        id_lba28_out,
   output logic [47:0]        id_lba48_out,
   output logic               access_abort_out
);
   import malc_pkg::*;

   // Everything the block remembers, registered as one word
   typedef struct packed {
      // Command engine and password sector intake
      malc_phase_e phase;
      malc_lock_e  lock;
      logic [2:0]  tries;
      logic [7:0]  word;
      logic        mism;
      // Command history and one-shot protection flags
      logic        after_rnm;
      logic        after_rnmx;
      logic        hpa28;
      logic        nv_done;
      logic        hob;
      // Task file bytes, current and previous
      logic [7:0]  feat;
      logic [7:0]  scnt_c;
      logic [7:0]  scnt_p;
      logic [7:0]  snum_c;
      logic [7:0]  snum_p;
      logic [7:0]  cyllo_c;
      logic [7:0]  cyllo_p;
      logic [7:0]  cylhi_c;
      logic [7:0]  cylhi_p;
      logic [7:0]  devhd;
      // Completion status, error and read data
      logic [7:0]  stat;
      logic [7:0]  err;
      logic [15:0] rdata;
      // Capacity limit and the identify words
      logic [47:0] max_lba;
      logic        max_nv;
      logic [27:0] id28;
      logic [47:0] id48;
      // Registered media access verdict
      logic        acc_abort;
   } malc_state_s;

   // Current and next state
   malc_state_s st_ff;
   malc_state_s nxt_st;

   // Pick current or previous byte by the HOB select
   // Reads show the previous bytes while HOB is set
   function automatic logic [7:0] malc_sel(input logic hob, input logic [7:0] cur,
                                           input logic [7:0] prev);
      malc_sel = hob ? prev : cur;
   endfunction

   // Status and error for a completed command
   function automatic logic [15:0] malc_done(input logic abort);
      logic [7:0] s;
      logic [7:0] e;
      s = MALC_STAT_RST;
      e = 8'h00;
      s[MALC_ST_ERR] = abort;
      e[MALC_ER_ABT] = abort;
      malc_done = {s, e};
   endfunction

   // Status while the host still owes the password sector
   function automatic logic [15:0] malc_wait();
      logic [7:0] s;
      s = MALC_STAT_RST;
      s[MALC_ST_DRQ] = 1'b1;
      malc_wait = {s, 8'h00};
   endfunction

   // Decoded task file views and prepared completions
   logic [47:0] req48;
   logic [47:0] req28;
   logic        nv_req;
   logic        ext_abort;
   logic [15:0] done_ok;
   logic [15:0] done_ab;
   logic [15:0] pwd_word;

   // Requested addresses and the extended set abort decision
   always_comb begin
      // Previous bytes form the upper half
      req48 = {st_ff.cylhi_p, st_ff.cyllo_p, st_ff.snum_p,
               st_ff.cylhi_c, st_ff.cyllo_c, st_ff.snum_c};
      // The 28-bit form keeps its top nibble in device/head
      req28 = {20'h0_0000, st_ff.devhd[3:0], st_ff.cylhi_c, st_ff.cyllo_c, st_ff.snum_c};
      nv_req = st_ff.scnt_c[MALC_SC_NV];
      // Every reason to refuse the extended set in one flag;
      // a second retained set waits for the next reset
      ext_abort = !supported_in || (req48 > native_max_in) || st_ff.hpa28
                  || !st_ff.after_rnmx || (st_ff.lock != MALC_UNLOCKED)
                  || (nv_req && (st_ff.nv_done || offset_mode_in));
      done_ok = malc_done(1'b0);
      done_ab = malc_done(1'b1);
      // Word 1 lines up with the lowest password bits
      pwd_word = stored_pwd_in[{st_ff.word[3:0] - 4'h1, 4'h0} +: 16];
   end

   // Next state: register port, command engine, data phase, access check
   always_comb begin
      nxt_st = st_ff;
      // Read data stands one cycle, then falls back to zero
      nxt_st.rdata = 16'h0000;
      // Media check uses the limit already in force
      nxt_st.acc_abort = access_req_in && (access_lba_in > st_ff.max_lba);
      // Register reads, data valid the cycle after the strobe
      if (rd_stb_in) begin
         unique case (addr_in)
            MALC_A_FEAT:   nxt_st.rdata = {8'h00, st_ff.err};
            MALC_A_SCNT:   nxt_st.rdata = {8'h00, malc_sel(st_ff.hob, st_ff.scnt_c, st_ff.scnt_p)};
            MALC_A_SNUM:   nxt_st.rdata = {8'h00, malc_sel(st_ff.hob, st_ff.snum_c, st_ff.snum_p)};
            MALC_A_CYLLO:  nxt_st.rdata = {8'h00, malc_sel(st_ff.hob, st_ff.cyllo_c, st_ff.cyllo_p)};
            MALC_A_CYLHI:  nxt_st.rdata = {8'h00, malc_sel(st_ff.hob, st_ff.cylhi_c, st_ff.cylhi_p)};
            MALC_A_DEVHD:  nxt_st.rdata = {8'h00, st_ff.devhd};
            // Status reads have no side effect
            MALC_A_CMD:    nxt_st.rdata = {8'h00, st_ff.stat};
            // Device control reads back only HOB
            MALC_A_DEVCTL: nxt_st.rdata = {8'h00, st_ff.hob, 7'h00};
            // Lock info: tries, state and flags
            MALC_A_LOCKST: nxt_st.rdata = {8'h00, st_ff.tries, st_ff.lock, st_ff.nv_done,
                                           st_ff.hpa28, st_ff.max_nv};
            // Unmapped reads return zero
            default:       nxt_st.rdata = 16'h0000;
         endcase
      end
      // Register writes and command execution
      if (wr_stb_in) begin
         unique case (addr_in)
            MALC_A_DATA: begin
               // Password sector intake, words 1 to 16 compared
               if (st_ff.phase == MALC_DATA) begin
                  // Any wrong password word fails the attempt
                  if (st_ff.word >= MALC_PWD_FIRST && st_ff.word <= MALC_PWD_LAST
                      && wr_data_in != pwd_word) begin
                     nxt_st.mism = 1'b1;
                  end
                  nxt_st.word = st_ff.word + 8'h01;
                  // Last word closes the phase and settles the outcome
                  if (st_ff.word == MALC_SECT_LAST) begin
                     nxt_st.phase = MALC_IDLE;
                     nxt_st.word = 8'h00;
                     // No wrap: a zero count never enters this phase
                     if (st_ff.mism || (st_ff.word <= MALC_PWD_LAST && wr_data_in != pwd_word)) begin
                        nxt_st.tries = st_ff.tries - 3'h1;
                        {nxt_st.stat, nxt_st.err} = done_ab;
                     end else begin
                        nxt_st.lock = MALC_UNLOCKED;
                        {nxt_st.stat, nxt_st.err} = done_ok;
                     end
                  end
               end
            end
            // Feature, count, address and device/head writes clear HOB; count and address bytes shift current into previous
            MALC_A_FEAT: begin
               nxt_st.feat = wr_data_in[7:0];
               nxt_st.hob = 1'b0;
            end
            // Sector count bit 0 carries the retention choice
            MALC_A_SCNT: begin
               nxt_st.scnt_p = st_ff.scnt_c;
               nxt_st.scnt_c = wr_data_in[7:0];
               nxt_st.hob = 1'b0;
            end
            MALC_A_SNUM: begin
               nxt_st.snum_p = st_ff.snum_c;
               nxt_st.snum_c = wr_data_in[7:0];
               nxt_st.hob = 1'b0;
            end
            MALC_A_CYLLO: begin
               nxt_st.cyllo_p = st_ff.cyllo_c;
               nxt_st.cyllo_c = wr_data_in[7:0];
               nxt_st.hob = 1'b0;
            end
            MALC_A_CYLHI: begin
               nxt_st.cylhi_p = st_ff.cylhi_c;
               nxt_st.cylhi_c = wr_data_in[7:0];
               nxt_st.hob = 1'b0;
            end
            MALC_A_DEVHD: begin
               nxt_st.devhd = wr_data_in[7:0];
               nxt_st.hob = 1'b0;
            end
            // Device control only carries the HOB select
            MALC_A_DEVCTL: nxt_st.hob = wr_data_in[MALC_DC_HOB];
            MALC_A_CMD: begin
               // Any command ends the read-native adjacency
               // and starts from an abort unless accepted below
               nxt_st.after_rnm = 1'b0;
               nxt_st.after_rnmx = 1'b0;
               nxt_st.hob = 1'b0;
               nxt_st.phase = MALC_IDLE;
               nxt_st.word = 8'h00;
               nxt_st.mism = 1'b0;
               {nxt_st.stat, nxt_st.err} = done_ab;
               unique case (wr_data_in[7:0])
                  // Read native: capacity into the 28-bit bytes
                  MALC_OP_RNM: begin
                     nxt_st.after_rnm = 1'b1;
                     nxt_st.snum_c = native_max_in[7:0];
                     nxt_st.cyllo_c = native_max_in[15:8];
                     nxt_st.cylhi_c = native_max_in[23:16];
                     // Top nibble keeps the drive and mode bits
                     nxt_st.devhd = {st_ff.devhd[7:4], native_max_in[27:24]};
                     {nxt_st.stat, nxt_st.err} = done_ok;
                  end
                  // Extended read native: six bytes, arms the 48-bit set
                  MALC_OP_RNMX: begin
                     nxt_st.after_rnmx = 1'b1;
                     {nxt_st.snum_c, nxt_st.cyllo_c, nxt_st.cylhi_c} =
                        {native_max_in[7:0], native_max_in[15:8], native_max_in[23:16]};
                     {nxt_st.snum_p, nxt_st.cyllo_p, nxt_st.cylhi_p} =
                        {native_max_in[31:24], native_max_in[39:32], native_max_in[47:40]};
                     {nxt_st.stat, nxt_st.err} = done_ok;
                  end
                  // Subcommands, or plain set right after read native
                  MALC_OP_SETMAX: begin
                     if (st_ff.after_rnm) begin
                        // Plain 28-bit set max address
                        if (st_ff.lock == MALC_UNLOCKED && req28 <= native_max_in) begin
                           nxt_st.max_lba = req28;
                           nxt_st.id28 = req28[27:0];
                           nxt_st.id48 = req28;
                           // Protected area now blocks any extended set
                           nxt_st.hpa28 = 1'b1;
                           nxt_st.max_nv = 1'b0;
                           {nxt_st.stat, nxt_st.err} = done_ok;
                        end
                     end else if (st_ff.lock == MALC_FROZEN) begin
                        // Frozen refuses every subcommand alike
                        {nxt_st.stat, nxt_st.err} = done_ab;
                     end else if (st_ff.feat == MALC_FT_UNLOCK) begin
                        // Exhausted counter leaves the abort in place
                        if (st_ff.tries != 3'h0) begin
                           nxt_st.phase = MALC_DATA;
                           {nxt_st.stat, nxt_st.err} = malc_wait();
                        end
                     end else if (st_ff.feat == MALC_FT_FREEZE) begin
                        // Freeze sticks until reset
                        nxt_st.lock = MALC_FROZEN;
                        {nxt_st.stat, nxt_st.err} = done_ok;
                     end else if (st_ff.feat == MALC_FT_LOCK) begin
                        // Locked still allows unlock and freeze
                        nxt_st.lock = MALC_LOCKED;
                        {nxt_st.stat, nxt_st.err} = done_ok;
                     end
                  end
                  // Extended set: 48-bit limit, optional retention
                  MALC_OP_SETMX: begin
                     if (!ext_abort) begin
                        nxt_st.max_lba = req48;
                        nxt_st.max_nv = nv_req;
                        nxt_st.id48 = req48;
                        // Small limits also reach the 28-bit words
                        if (req48 <= MALC_LIM28) begin
                           nxt_st.id28 = req48[27:0];
                        end
                        // Retained set used up until the next reset
                        if (nv_req) begin
                           nxt_st.nv_done = 1'b1;
                        end
                        {nxt_st.stat, nxt_st.err} = done_ok;
                     end
                  end
                  // Unknown opcodes abort
                  default: {nxt_st.stat, nxt_st.err} = done_ab;
               endcase
            end
            // Unmapped writes are ignored
            default: nxt_st.hob = st_ff.hob;
         endcase
      end
   end

   // State register, reset puts counter at five and clears freeze
   // Reset drops any limit too: no separate power domain here
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff <= '0;
         st_ff.phase <= MALC_IDLE;
         st_ff.lock <= MALC_UNLOCKED;
         st_ff.tries <= MALC_TRIES_RST;
         st_ff.stat <= MALC_STAT_RST;
         // No limit until software sets one
         st_ff.max_lba <= '1;
         st_ff.id48 <= '1;
         st_ff.id28 <= '1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state register
   // Data request is the one-bit phase flop itself
   assign rd_data_out      = st_ff.rdata;
   assign drq_out          = st_ff.phase == MALC_DATA;
   assign max_lba_out      = st_ff.max_lba;
   assign max_nv_out       = st_ff.max_nv;
   assign id_lba28_out     = st_ff.id28;
   assign id_lba48_out     = st_ff.id48;
   assign access_abort_out = st_ff.acc_abort;

endmodule // malc_top
`default_nettype wire

// [sim/malc_host_model.sv]
// Host controller model driving the task file register port
`timescale 1ns/1ps
`default_nettype none
module malc_host_model (
   input  wire logic        clk_in,
   input  wire logic [15:0] rd_data_in,
   output logic [3:0]       addr_out,
   output logic [15:0]      wr_data_out,
   output logic             wr_stb_out,
   output logic             rd_stb_out
);
   import malc_pkg::*;
   // Idle bus at time zero
   initial begin
      addr_out = 4'h0;
      wr_data_out = 16'h0000;
      wr_stb_out = 1'b0;
      rd_stb_out = 1'b0;
   end
   // One-cycle write; released lines show the inverse
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wr_data_out <= d;
      wr_stb_out <= 1'b1;
      @(posedge clk_in);
      wr_stb_out <= 1'b0;
      wr_data_out <= ~d;
      addr_out <= ~a;
   endtask
   // Read strobe; data taken in the cycle after it
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_stb_out <= 1'b1;
      @(posedge clk_in);
      rd_stb_out <= 1'b0;
      addr_out <= ~a;
      @(negedge clk_in);
      d = rd_data_in;
   endtask
   // Feature-selected subcommand
   task automatic sub(input logic [7:0] f);
      wr(MALC_A_FEAT, {8'h00, f});
      wr(MALC_A_CMD, {8'h00, MALC_OP_SETMAX});
   endtask
   // Unlock with one sector, password in words 1 to 16
   task automatic unlock(input logic [255:0] pw);
      sub(MALC_FT_UNLOCK);
      for (int i = 0; i < 256; i++) begin
         wr(MALC_A_DATA, (i > 0 && i < 17) ? pw[((i - 1) & 15) * 16 +: 16] : 16'h0000);
      end
   endtask
   // Extended set, previous bytes before current ones
   task automatic set48(input logic [47:0] v, input logic b, input logic pre);
      if (pre) begin
         wr(MALC_A_CMD, {8'h00, MALC_OP_RNMX});
      end
      wr(MALC_A_SCNT, {15'h0000, b});
      wr(MALC_A_SNUM, {8'h00, v[31:24]});
      wr(MALC_A_CYLLO, {8'h00, v[39:32]});
      wr(MALC_A_CYLHI, {8'h00, v[47:40]});
      wr(MALC_A_SNUM, {8'h00, v[7:0]});
      wr(MALC_A_CYLLO, {8'h00, v[15:8]});
      wr(MALC_A_CYLHI, {8'h00, v[23:16]});
      wr(MALC_A_CMD, {8'h00, MALC_OP_SETMX});
   endtask
endmodule // malc_host_model
`default_nettype wire

// [sim/malc_top_properties.sv]
// Assertion checker for the max-address lock and set block
`timescale 1ns/1ps
`default_nettype none
module malc_checker (
   input wire logic        clk_in,
   input wire logic        arst_n_in,
   input wire logic [3:0]  addr_in,
   input wire logic [15:0] wr_data_in,
   input wire logic        wr_stb_in,
   input wire logic        rd_stb_in,
   input wire logic [47:0] native_max_in,
   input wire logic        access_req_in,
   input wire logic [47:0] access_lba_in,
   input wire logic [15:0] rd_data_out,
   input wire logic        drq_out,
   input wire logic [47:0] max_lba_out,
   input wire logic [27:0] id_lba28_out,
   input wire logic [47:0] id_lba48_out,
   input wire logic        access_abort_out
);
   import malc_pkg::*;
   logic cmd_wr;
   // Command register write this cycle
   assign cmd_wr = wr_stb_in && addr_in == MALC_A_CMD;
   // One domain, reset disables all checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   a_abort_above: assert property (access_req_in && access_lba_in > max_lba_out |=> access_abort_out)
      else $error("access above max not aborted");
   a_abort_none: assert property (!access_req_in || access_lba_in <= max_lba_out |=> !access_abort_out)
      else $error("access aborted without cause");
   a_id48_match: assert property (id_lba48_out == max_lba_out)
      else $error("identify 48-bit words differ from max");
   a_id28_keep: assert property ($changed(max_lba_out) && max_lba_out > MALC_LIM28 |-> $stable(id_lba28_out))
      else $error("identify 28-bit words changed for large max");
   a_id28_track: assert property ($changed(max_lba_out) && max_lba_out <= MALC_LIM28 |-> id_lba28_out == max_lba_out[27:0])
      else $error("identify 28-bit words not updated");
   a_max_native: assert property ($changed(max_lba_out) |-> max_lba_out <= native_max_in && $past(cmd_wr))
      else $error("max set beyond capacity or without command");
   a_drq_start: assert property ($rose(drq_out) |-> $past(cmd_wr && wr_data_in[7:0] == MALC_OP_SETMAX))
      else $error("data phase without unlock command");
   a_drq_hold: assert property ($rose(drq_out) |-> drq_out [*8])
      else $error("data phase ended early");
   a_drq_end: assert property ($fell(drq_out) |-> $past(wr_stb_in && addr_in == MALC_A_DATA))
      else $error("data phase ended without data write");
   a_status_clean: assert property ($past(rd_stb_in && addr_in == MALC_A_CMD) |-> !rd_data_out[7] && !rd_data_out[5])
      else $error("status shows busy or fault");
   // Main scenarios reached
   c_unlock_done: cover property ($fell(drq_out));
   c_media_abort: cover property (access_abort_out);
   c_big_max: cover property ($changed(max_lba_out) && max_lba_out > MALC_LIM28);
endmodule // malc_checker
bind malc_top malc_checker malc_checker_inst (.clk_in, .arst_n_in, .addr_in, .wr_data_in,
   .wr_stb_in, .rd_stb_in, .native_max_in, .access_req_in, .access_lba_in, .rd_data_out,
   .drq_out, .max_lba_out, .id_lba28_out, .id_lba48_out, .access_abort_out);
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the max-address lock and set block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import malc_pkg::*;
   localparam logic [47:0] NAT = 48'h0001_0000_0000;
   logic         clk_in = 1'b0, arst_n_in = 1'b0, sup = 1'b1, ofs = 1'b0, req = 1'b0;
   logic         wstb, rstb, drq, nv, abt;
   logic [3:0]   addr;
   logic [15:0]  wdat, rdat, d;
   logic [27:0]  i28;
   logic [47:0]  lba = 48'h0000_0000_0000, mx, i48, v;
   logic [255:0] pw;
   logic [31:0]  s = 32'h0fbe;
   int           n_mismatch = 0, num_checks = 0, cyc = 0;
   // Clock and hang guard
   initial forever #2 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   malc_host_model h (.clk_in, .rd_data_in(rdat), .addr_out(addr), .wr_data_out(wdat),
      .wr_stb_out(wstb), .rd_stb_out(rstb));
   malc_top malc_top_inst (.clk_in, .arst_n_in, .addr_in(addr), .wr_data_in(wdat),
      .wr_stb_in(wstb), .rd_stb_in(rstb), .supported_in(sup), .offset_mode_in(ofs),
      .native_max_in(NAT), .stored_pwd_in(pw), .access_req_in(req), .access_lba_in(lba),
      .rd_data_out(rdat), .drq_out(drq), .max_lba_out(mx), .max_nv_out(nv),
      .id_lba28_out(i28), .id_lba48_out(i48), .access_abort_out(abt));
   // Random source and expectations
   function automatic logic [31:0] xs();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [27:0] e28(input logic [47:0] n, input logic [27:0] o);
      return (n <= MALC_LIM28) ? n[27:0] : o;
   endfunction
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   // Status and error after a command
   task automatic st(input logic ab);
      h.rd(MALC_A_CMD, d);
      chk("status", MALC_STAT_RST | ab, d);
      h.rd(MALC_A_FEAT, d);
      chk("error", {47'h0, ab} << MALC_ER_ABT, d);
   endtask
   task automatic lkc(input logic [2:0] t, input logic [1:0] m);
      h.rd(MALC_A_LOCKST, d);
      chk("lock", {t, m}, d[7:3]);
   endtask
   task automatic rst();
      @(posedge clk_in);
      arst_n_in <= 1'b0;
      repeat (20) @(posedge clk_in);
      arst_n_in <= 1'b1;
   endtask
   task automatic final_report();
      if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      for (int k = 0; k < 8; k++) pw[k * 32 +: 32] <= xs();
      rst();
      lkc(3'd5, MALC_UNLOCKED);
      h.rd(4'hA, d);
      chk("unmapped", 48'h0, d);
      for (int j = 0; j < 4; j++) begin
         @(posedge clk_in);
         sup <= (j != 2);
         ofs <= (j == 3);
         h.set48((j == 1) ? NAT + 1 : 48'h0000_0000_0010, j == 3, j != 0);
         st(1'b1);
      end
      chk("max", 48'hFFFF_FFFF_FFFF, mx);
      @(posedge clk_in);
      sup <= 1'b1;
      ofs <= 1'b0;
      v = {16'h0000, xs() | 32'h1000_0000} & 48'h0000_1FFF_FFFF;
      h.set48(v, 1'b0, 1'b1);
      st(1'b0);
      chk("max", v, mx);
      chk("id48", v, i48);
      chk("id28", e28(v, 28'hFFF_FFFF), i28);
      h.wr(MALC_A_DEVCTL, 16'h0080);
      h.rd(MALC_A_SNUM, d);
      chk("snum_hob", v[31:24], d);
      h.rd(MALC_A_CYLHI, d);
      chk("cylhi_hob", v[47:40], d);
      h.wr(MALC_A_DEVCTL, 16'h0000);
      h.rd(MALC_A_SNUM, d);
      chk("snum", v[7:0], d);
      @(posedge clk_in);
      req <= 1'b1;
      lba <= v + 1;
      @(posedge clk_in);
      lba <= v;
      @(negedge clk_in);
      chk("abort", 48'h1, abt);
      @(posedge clk_in);
      req <= 1'b0;
      @(negedge clk_in);
      chk("abort", 48'h0, abt);
      v = {16'h0000, xs()} & MALC_LIM28;
      h.set48(v, 1'b1, 1'b1);
      st(1'b0);
      chk("id28", e28(v, 28'hFFF_FFFF), i28);
      chk("nv", 48'h1, nv);
      h.set48(v, 1'b1, 1'b1);
      st(1'b1);
      h.wr(MALC_A_CMD, {8'h00, MALC_OP_RNM});
      h.sub(MALC_FT_UNLOCK);
      @(negedge clk_in);
      chk("drq", 48'h0, drq);
      chk("max", {20'h0_0000, NAT[27:0]}, mx);
      h.set48(v, 1'b0, 1'b1);
      st(1'b1);
      rst();
      for (int k = 4; k >= 0; k--) begin
         h.unlock(pw ^ (256'h1 << (xs() & 32'h0000_00FF)));
         st(1'b1);
         lkc(k[2:0], MALC_UNLOCKED);
      end
      h.unlock(pw);
      st(1'b1);
      rst();
      lkc(3'd5, MALC_UNLOCKED);
      h.sub(MALC_FT_LOCK);
      h.set48(v, 1'b0, 1'b1);
      st(1'b1);
      h.unlock(pw);
      st(1'b0);
      lkc(3'd5, MALC_UNLOCKED);
      h.set48(v, 1'b0, 1'b1);
      st(1'b0);
      h.sub(MALC_FT_FREEZE);
      lkc(3'd5, MALC_FROZEN);
      for (int j = 1; j < 4; j++) begin
         h.sub(j[7:0]);
         st(1'b1);
      end
      h.set48(v, 1'b0, 1'b1);
      st(1'b1);
      rst();
      lkc(3'd5, MALC_UNLOCKED);
      h.wr(MALC_A_CMD, 16'h0000);
      st(1'b1);
      h.sub(MALC_FT_UNLOCK);
      @(negedge clk_in);
      chk("drq", 48'h1, drq);
      h.rd(MALC_A_CMD, d);
      chk("status", MALC_STAT_RST | (48'h1 << MALC_ST_DRQ), d);
      final_report();
   end
endmodule // testbench
`default_nettype wire
